// >>> pkg/clock_gear_cfg.svh
// offsets, field positions, reset values and timing counts of the clock controller
`ifndef CLOCK_GEAR_CFG_SVH
`define CLOCK_GEAR_CFG_SVH
`define OFS_OSC_PRESC 8'he0
`define OFS_SRC_GEAR 8'he1
`define OFS_WARM_HALT 8'he2
`define OFS_DOUBLER 8'he8
`define RST_OSC_PRESC 8'he0
`define RST_SRC_GEAR 8'h04
`define RST_WARM_HALT 8'h2c
`define RST_DOUBLER 8'h00
`define BIT_FAST_EN 7
`define BIT_SLOW_EN 6
`define BIT_FAST_AFTER 5
`define BIT_SLOW_AFTER 4
`define BIT_AFTER_SEL 3
`define BIT_WARM_START 2
`define BIT_SYS_SEL 3
`define BIT_PIN_MODE 1
`define BIT_PIN_HOLD 0
`define WARM_EXP_SHORT 8
`define WARM_EXP_MID 14
`define WARM_EXP_LONG 16
`define PRESC_DIV 16
`define RESET_STATES 10
`endif

// >>> pkg/clock_gear_pkg.sv
// types of the clock controller
package clock_gear_pkg;
    typedef enum logic [1:0] {
        halt_reserved,
        halt_stop,
        halt_light_one,
        halt_light_two
    } halt_type;
    typedef enum logic [1:0] {
        presc_gear,
        presc_res1,
        presc_fc16,
        presc_res3
    } presc_type;
endpackage

// >>> design/clock_divider_cell.sv
// glitch-free clock-enable divider by a power of two
`timescale 1ns/1ps
`default_nettype none
module clock_divider_cell #(
    parameter int WIDTH = 4
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic [2:0] i_shift,
    output logic o_tick
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] mask;
    assign mask = WIDTH'((1 << i_shift) - 1);
    // terminal count only at wrap, no short pulse
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            count <= '0;
        end else if ((count & mask) == mask) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end
    assign o_tick = ((count & mask) == mask);
endmodule
`default_nettype wire

// >>> design/system_clock_gear_control.sv
// system clock gear controller with apb register slave
// Summary of operation
// - reset leaves doubler pass-through and gear at divide by sixteen
// - source register bit 3 selects fc (0) or fs (1), reset 0
// - system clock is fc divided by the gear, or fs undivided; two such periods make one state
// - control bits 7 and 6 enable fast and slow oscillators, reset 1
// - bits 5 and 4 set oscillators running after stop, reset 1 and 0
// - bit 3 selects clock after stop: fc or fs, reset 0
// - writing 1 to bit 2 starts warm-up; reads 1 while running
// - prescaler field 00 selects state tick, 10 selects fc/16 only while gear divides by sixteen
// - warm-up field codes 01,10,11 give 2^8,2^14,2^16 cycles, reset 10
// - halt field 01 stop, 10 light sleep one, 11 light sleep two
// - pin bit 0: 0 switches io off, 1 holds pin state
// - bit 1 chooses whether pin bit applies to stop or light sleep one
// - gear field divides fc by 1,2,4,8,16; reset 100
// - enabled doubler runs at four times fc; reset stopped
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gear_cfg.svh"
module system_clock_gear_control #(
    parameter int WARM_WIDTH = 17
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic i_fc_tick,
    input wire logic i_fs_tick,
    input wire logic i_halt_request,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_fast_osc_enable,
    output logic o_slow_osc_enable,
    output logic o_source_is_slow,
    output logic o_system_state_tick,
    output logic o_prescaler_tick,
    output logic o_doubler_run,
    output logic o_doubler_select,
    output logic o_halt_stop,
    output logic o_halt_light_one,
    output logic o_halt_light_two,
    output logic o_pins_hold,
    output logic o_pins_off
);
    logic [7:0] osc_presc;
    logic [7:0] src_gear;
    logic [7:0] warm_halt;
    logic [7:0] doubler;
    logic warm_busy;
    logic [WARM_WIDTH-1:0] warm_count;
    logic [WARM_WIDTH-1:0] warm_limit;
    logic access;
    logic wr;
    logic mapped;
    logic [7:0] rd_byte;
    logic gear_tick;
    logic fc16_tick;
    logic [2:0] gear_shift;
    logic src_tick;
    logic half_phase;
    logic next_state_tick;
    logic next_presc_tick;
    clock_gear_pkg::halt_type halt_mode;
    clock_gear_pkg::presc_type presc_sel;

    function automatic logic is_reg(input logic [11:0] addr, input logic [7:0] ofs);
        is_reg = (addr == {2'b00, ofs, 2'b00});
    endfunction

    assign access = i_psel && i_penable;
    assign wr = access && i_pwrite && i_pstrb[0];
    assign mapped = is_reg(i_paddr, `OFS_OSC_PRESC) || is_reg(i_paddr, `OFS_SRC_GEAR)
        || is_reg(i_paddr, `OFS_WARM_HALT) || is_reg(i_paddr, `OFS_DOUBLER);
    assign halt_mode = clock_gear_pkg::halt_type'(warm_halt[3:2]);
    assign presc_sel = clock_gear_pkg::presc_type'(osc_presc[1:0]);

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            osc_presc <= `RST_OSC_PRESC;
            src_gear <= `RST_SRC_GEAR;
            warm_halt <= `RST_WARM_HALT;
            doubler <= `RST_DOUBLER;
        end else if (wr) begin
            if (is_reg(i_paddr, `OFS_OSC_PRESC)) begin
                osc_presc <= {i_pwdata[7:3], 1'b0, i_pwdata[1:0]};
            end
            if (is_reg(i_paddr, `OFS_SRC_GEAR)) begin
                src_gear <= {4'h0, i_pwdata[3:0]};
            end
            if (is_reg(i_paddr, `OFS_WARM_HALT)) begin
                warm_halt <= {2'b00, i_pwdata[5:0]};
            end
            if (is_reg(i_paddr, `OFS_DOUBLER)) begin
                doubler <= {i_pwdata[7:6], 1'b0, i_pwdata[4], 4'h0};
            end
        end
    end

    always_comb begin
        case (warm_halt[5:4])
            2'b01: warm_limit = WARM_WIDTH'(1 << `WARM_EXP_SHORT);
            2'b10: warm_limit = WARM_WIDTH'(1 << `WARM_EXP_MID);
            2'b11: warm_limit = WARM_WIDTH'(1 << `WARM_EXP_LONG);
            default: warm_limit = WARM_WIDTH'(1 << `WARM_EXP_MID);
        endcase
    end

    // warm-up timer, counts the target oscillator
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            warm_busy <= 1'b0;
            warm_count <= '0;
        end else if (wr && is_reg(i_paddr, `OFS_OSC_PRESC) && i_pwdata[`BIT_WARM_START]) begin
            warm_busy <= 1'b1;
            warm_count <= '0;
        end else if (warm_busy) begin
            if (src_gear[`BIT_SYS_SEL] ? i_fc_tick : i_fs_tick) begin
                if (warm_count == warm_limit - 1'b1) begin
                    warm_busy <= 1'b0;
                end
                warm_count <= warm_count + 1'b1;
            end
        end
    end

    // gear code to shift, reserved codes fall back to sixteen
    always_comb begin
        case (src_gear[2:0])
            3'b000: gear_shift = 3'd0;
            3'b001: gear_shift = 3'd1;
            3'b010: gear_shift = 3'd2;
            3'b011: gear_shift = 3'd3;
            default: gear_shift = 3'd4;
        endcase
    end

    clock_divider_cell #(.WIDTH(4)) gear_div (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_shift(gear_shift),
        .o_tick(gear_tick)
    );

    assign fc16_tick = gear_tick && (gear_shift == 3'd4);
    // fc gear or fs as selected source
    assign src_tick = src_gear[`BIT_SYS_SEL] ? i_fs_tick : (gear_tick && i_fc_tick);

    // state is half the selected source
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            half_phase <= 1'b0;
        end else if (src_tick) begin
            half_phase <= ~half_phase;
        end
    end
    assign next_state_tick = src_tick && half_phase;

    always_comb begin
        case (presc_sel)
            clock_gear_pkg::presc_gear: next_presc_tick = next_state_tick;
            clock_gear_pkg::presc_fc16: next_presc_tick = fc16_tick && i_fc_tick;
            default: next_presc_tick = 1'b0;
        endcase
    end

    always_comb begin
        case (i_paddr[9:2])
            `OFS_OSC_PRESC: rd_byte = {osc_presc[7:3], warm_busy, osc_presc[1:0]};
            `OFS_SRC_GEAR: rd_byte = src_gear;
            `OFS_WARM_HALT: rd_byte = warm_halt;
            `OFS_DOUBLER: rd_byte = doubler;
            default: rd_byte = 8'h00;
        endcase
    end

    // apb answer registered in setup, no wait state
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (i_psel && !i_penable) begin
            o_pready <= 1'b1;
            o_prdata <= {24'h000000, rd_byte};
            o_pslverr <= !mapped;
        end else begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
    end

    // halt mode and pin control outputs
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_halt_stop <= 1'b0;
            o_halt_light_one <= 1'b0;
            o_halt_light_two <= 1'b0;
            o_pins_hold <= 1'b0;
            o_pins_off <= 1'b0;
        end else begin
            o_halt_stop <= i_halt_request && (halt_mode == clock_gear_pkg::halt_stop);
            o_halt_light_one <= i_halt_request && (halt_mode == clock_gear_pkg::halt_light_one);
            o_halt_light_two <= i_halt_request && (halt_mode == clock_gear_pkg::halt_light_two);
            // pin bit applies to chosen mode
            if (i_halt_request && (warm_halt[`BIT_PIN_MODE]
                ? halt_mode == clock_gear_pkg::halt_light_one
                : halt_mode == clock_gear_pkg::halt_stop)) begin
                o_pins_hold <= warm_halt[`BIT_PIN_HOLD];
                o_pins_off <= !warm_halt[`BIT_PIN_HOLD];
            end else begin
                o_pins_hold <= 1'b0;
                o_pins_off <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_fast_osc_enable <= 1'b1;
            o_slow_osc_enable <= 1'b1;
            o_source_is_slow <= 1'b0;
            o_system_state_tick <= 1'b0;
            o_prescaler_tick <= 1'b0;
            o_doubler_run <= 1'b0;
            o_doubler_select <= 1'b0;
        end else begin
            o_fast_osc_enable <= osc_presc[`BIT_FAST_EN];
            o_slow_osc_enable <= osc_presc[`BIT_SLOW_EN];
            o_source_is_slow <= src_gear[`BIT_SYS_SEL];
            o_system_state_tick <= next_state_tick;
            o_prescaler_tick <= next_presc_tick;
            // doubler runs unless action 00, selected on 10
            o_doubler_run <= doubler[7] || doubler[6];
            o_doubler_select <= doubler[7] && !doubler[6];
        end
    end
endmodule
`default_nettype wire

// >>> tb/system_clock_gear_control_assertions.sv
// port assertions of the clock controller
`timescale 1ns/1ps
`default_nettype none
module system_clock_gear_control_assertions (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_fast_osc_enable,
    input wire logic o_slow_osc_enable,
    input wire logic o_halt_stop,
    input wire logic o_halt_light_one,
    input wire logic o_halt_light_two,
    input wire logic o_pins_hold,
    input wire logic o_pins_off
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    logic wr_osc;
    assign wr_osc = o_pready && i_pwrite && i_pstrb[0] && i_paddr == 12'h380;
    chk_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    chk_ready_one_cycle: assert property (o_pready |=> !o_pready)
        else $error("ready held");
    chk_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
        else $error("ready outside access");
    chk_error_no_data: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error with data");
    chk_fast_osc_write: assert property (
        wr_osc |-> ##2 o_fast_osc_enable == $past(i_pwdata[7], 2)) else $error("fast enable");
    chk_slow_osc_write: assert property (
        wr_osc |-> ##2 o_slow_osc_enable == $past(i_pwdata[6], 2)) else $error("slow enable");
    chk_halt_one_mode: assert property (
        $onehot0({o_halt_stop, o_halt_light_one, o_halt_light_two})) else $error("halt modes");
    chk_pins_one_state: assert property (!(o_pins_hold && o_pins_off))
        else $error("pins hold and off");
endmodule
bind system_clock_gear_control system_clock_gear_control_assertions chk (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_fast_osc_enable(o_fast_osc_enable), .o_slow_osc_enable(o_slow_osc_enable),
    .o_halt_stop(o_halt_stop), .o_halt_light_one(o_halt_light_one),
    .o_halt_light_two(o_halt_light_two), .o_pins_hold(o_pins_hold), .o_pins_off(o_pins_off));
`default_nettype wire

// >>> tb/system_clock_gear_control_tb_top.sv
// self-checking bench of the clock controller
`timescale 1ns/1ps
`default_nettype none
module system_clock_gear_control_tb_top;
    logic i_clock = 0, i_resetn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic i_fc_tick = 1, i_fs_tick = 1, i_halt_request = 0, er;
    logic [11:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, rd, o_prdata;
    logic [3:0] i_pstrb = 0;
    logic o_pready, o_pslverr, o_fast_osc_enable, o_slow_osc_enable, o_source_is_slow;
    logic o_system_state_tick, o_prescaler_tick, o_doubler_run, o_doubler_select;
    logic o_halt_stop, o_halt_light_one, o_halt_light_two, o_pins_hold, o_pins_off;
    int miscompares = 0, checks = 0, cyc = 0, t0, i, ns = 0, np = 0;
    logic [1:0] h;
    logic [7:0] d;
    always #50 i_clock = ~i_clock;
    always @(posedge i_clock) cyc <= cyc + 1;
    system_clock_gear_control DUT (.i_clock(i_clock), .i_resetn(i_resetn), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .i_pstrb(i_pstrb), .i_fc_tick(i_fc_tick), .i_fs_tick(i_fs_tick),
        .i_halt_request(i_halt_request), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_fast_osc_enable(o_fast_osc_enable),
        .o_slow_osc_enable(o_slow_osc_enable), .o_source_is_slow(o_source_is_slow),
        .o_system_state_tick(o_system_state_tick), .o_prescaler_tick(o_prescaler_tick),
        .o_doubler_run(o_doubler_run), .o_doubler_select(o_doubler_select),
        .o_halt_stop(o_halt_stop), .o_halt_light_one(o_halt_light_one),
        .o_halt_light_two(o_halt_light_two), .o_pins_hold(o_pins_hold),
        .o_pins_off(o_pins_off));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v,
        input logic [3:0] s);
        int n;
        n = 0;
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= {24'h0, v};
        i_pstrb <= s;
        @(posedge i_clock);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (o_pready !== 1'b1) begin
            miscompares++;
            end_of_test();
        end
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        apb(1'b1, a, v, 4'h1);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] v);
        apb(1'b0, a, 8'h0, 4'h1);
        chk(rd, {24'h0, v});
    endtask
    task automatic settle();
        repeat (4) @(posedge i_clock);
    endtask
    initial begin
        repeat (5) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(posedge i_clock);
        chk({o_fast_osc_enable, o_slow_osc_enable, o_doubler_run, o_source_is_slow}, 4'hc);
        repeat (320) begin
            @(posedge i_clock);
            ns += o_system_state_tick;
            np += o_prescaler_tick;
        end
        chk(ns, 10);
        chk(np, 10);
        rdchk(12'h380, 8'he0);
        rdchk(12'h384, 8'h04);
        rdchk(12'h388, 8'h2c);
        rdchk(12'h3a0, 8'h00);
        apb(1'b0, 12'h3fc, 8'h0, 4'h1);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 12'h384, 8'h0b, 4'h0);
        rdchk(12'h384, 8'h04);
        wr(12'h384, 8'h0b);
        rdchk(12'h384, 8'h0b);
        for (i = 0; i < 60 && o_source_is_slow !== 1'b1; i++) @(posedge i_clock);
        chk(o_source_is_slow, 1'b1);
        wr(12'h384, 8'h04);
        wr(12'h380, 8'h20);
        settle();
        chk({o_fast_osc_enable, o_slow_osc_enable}, 2'b00);
        wr(12'h380, 8'hd8);
        rdchk(12'h380, 8'hd8);
        wr(12'h380, 8'he2);
        rdchk(12'h380, 8'he2);
        wr(12'h380, 8'he0);
        wr(12'h388, 8'h1c);
        t0 = cyc;
        wr(12'h380, 8'he4);
        wr(12'h380, 8'he0);
        rdchk(12'h380, 8'he4);
        for (i = 0; i < 200 && rd[2] !== 1'b0; i++) apb(1'b0, 12'h380, 8'h0, 4'h1);
        chk(rd, 32'he0);
        chk(cyc - t0 >= 256 && cyc - t0 <= 280, 1'b1);
        i_halt_request <= 1'b1;
        for (i = 2; i < 8; i++) begin
            h = i[2:1];
            d = {4'h1, h, i[0], ~i[0]};
            wr(12'h388, d);
            rdchk(12'h388, d);
            settle();
            chk({o_halt_stop, o_halt_light_one, o_halt_light_two}, {h == 1, h == 2, h == 3});
            chk({o_pins_hold, o_pins_off}, {!i[0] && h == 1, i[0] && h == 2});
        end
        i_halt_request <= 1'b0;
        for (i = 1; i < 5; i++) begin
            d = {i[1:0], 6'h0};
            wr(12'h3a0, d);
            settle();
            chk({o_doubler_run, o_doubler_select}, {d != 0, d == 8'h80});
        end
        end_of_test();
    end
endmodule
`default_nettype wire
